// *** fcmd_handler.sv ***
`timescale 1ns/1ps
`include "fcmd_regs.svh"
// Functional notes
// RL1: Volatile write enable leaves the latch alone, only arms next status write volatile.
// RL2: Volatile write enable runs only if chip select rises after exactly eight bits.
// RL3: Four-line mode takes instruction and data as nibbles on all four lines.
// RL4: Status clear zeroes busy, write latch, program error and erase error bits; busy stays set while a program runs (code: not if erase error is set).
// RL5: Status clear needs no prior write enable.
// RL6: Status clear is accepted even while busy.
// RL7: Non-volatile pattern program is rejected unless the write latch is set.
// RL8: Non-volatile pattern program needs exactly one data byte, else it is discarded.
// RL9: Program starts at chip select rise, busy while running, then clears busy and latch; busy stays set if it failed.
// RL10: A failed non-volatile pattern program sets the program error flag.
// RL11: Host keeps serial clock at or below 133 MHz for pattern commands.
// RL12: Volatile pattern write is accepted only with the write latch set.
// RL13: Volatile pattern write takes exactly one data byte and applies at once.
// RL14: Pattern read waits one dummy cycle then shifts the byte out.
// RL15: Lines are ignored during the pattern read dummy cycle.
// RL16: Pattern byte repeats for as long as the host keeps clocking.
// RL17: Enter wide address sets the address length bit.
// RL18: Commands that only exist with four address bytes stay four-byte.
// RL19: Exit wide address clears the address length bit.
// RL20: Hardware or software reset reloads address length from the stored setting.
// RL21: The write-any-register path may also clear the address length bit.
// RL22: Write enable sets the write enable latch.
// RL23: Pattern read returns the volatile copy, loaded from the stored copy at reset.
module fcmd_handler (
   // Clocking
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // Link pins
   input  wire logic       i_cs_n,
   input  wire logic       i_sclk,
   input  wire logic [3:0] i_io,
   output logic      [3:0] o_io,
   output logic      [3:0] o_io_oe_n,
   // Configuration and stored settings
   input  wire logic       i_four_line_command_mode,
   input  wire logic [7:0] i_nv_learning_pattern,
   input  wire logic       i_nv_address_length_bit,
   input  wire logic       i_soft_reset,
   // Neighbouring command paths
   input  wire logic       i_write_any_register_clear_ads,
   input  wire logic       i_status_config_write_done,
   input  wire logic       i_erase_error_set,
   input  wire logic       i_nv_program_fail,
   // Status
   output logic      [7:0] o_volatile_status_register_1,
   output logic      [7:0] o_volatile_status_register_2,
   output logic            o_address_length_bit,
   output logic            o_volatile_write_armed,
   output logic      [7:0] o_learning_pattern,
   // Non-volatile pattern program request
   output logic            o_nv_program_start,
   output logic      [7:0] o_nv_program_data
);

   fcmd_pkg::fcmd_pins_t pins_raw;
   fcmd_pkg::fcmd_pins_t pins;
   fcmd_pkg::fcmd_state_t state_r;

   logic        sclk_d_r;
   logic        cs_d_r;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        cs_rise;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0]  bits_r;
   logic [4:0]  bits_nxt;
   logic [4:0]  step;
   logic [7:0]  opcode_r;
   logic        quad_r;
   logic [2:0]  out_idx_r;
   logic        wip_r;
   logic        wel_r;
   logic        perr_r;
   logic        eerr_r;
   logic        ads_r;
   logic        vol_armed_r;
   logic [7:0]  pattern_r;
   logic [15:0] prog_cnt_r;
   logic        prog_busy_r;
   logic        prog_start_r;
   logic [7:0]  prog_data_r;
   logic        exec_write_enable_cmd;
   logic        exec_volatile_write_enable_cmd;
   logic        exec_clear;
   logic        exec_nv_prog;
   logic        exec_vol_wr;
   logic        exec_enter;
   logic        exec_exit;
   logic        prog_done;
   logic        len8;
   logic        len16;

   assign pins_raw = '{cs_n: i_cs_n, sclk: i_sclk, io: i_io};

   fcmd_sync #(
      .W       (6)
   ) u_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_async (pins_raw),
      .o_level (pins)
   );

   // Edge finder on the filtered link levels
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
      end else if (i_ce) begin
         sclk_d_r <= pins.sclk;
         cs_d_r   <= pins.cs_n;
      end
   end

   assign sclk_rise = pins.sclk & ~sclk_d_r & ~pins.cs_n;
   assign sclk_fall = ~pins.sclk & sclk_d_r & ~pins.cs_n;
   assign cs_fall   = ~pins.cs_n & cs_d_r;
   assign cs_rise   = pins.cs_n & ~cs_d_r;

   // Mode frozen per frame so a mid-frame change cannot split a nibble
   assign step = quad_r ? 5'h04 : 5'h01; // see RL3

   always_comb begin
      shift_nxt = quad_r ? {shift_r[11:0], pins.io} : {shift_r[14:0], pins.io[0]}; // see RL3
      bits_nxt  = (bits_r >= (`FCMD_BIT_COUNT_MAX - step)) ? `FCMD_BIT_COUNT_MAX
                                                             : bits_r + step;
   end

   // Frame sequencer
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_r  <= fcmd_pkg::FCMD_ST_IDLE;
         shift_r  <= 16'h0000;
         bits_r   <= 5'h00;
         opcode_r <= 8'h00;
         quad_r   <= 1'b0;
      end else if (i_ce) begin
         if (cs_fall) begin
            state_r <= fcmd_pkg::FCMD_ST_INSTR;
            shift_r <= 16'h0000;
            bits_r  <= 5'h00;
            quad_r  <= i_four_line_command_mode;
         end else if (pins.cs_n) begin
            state_r <= fcmd_pkg::FCMD_ST_IDLE;
         end else if (sclk_rise) begin
            unique case (state_r)
               fcmd_pkg::FCMD_ST_INSTR: begin
                  shift_r <= shift_nxt;
                  bits_r  <= bits_nxt;
                  if (bits_nxt == `FCMD_INSTR_BITS) begin
                     opcode_r <= shift_nxt[7:0];
                     if (shift_nxt[7:0] == `FCMD_OP_PATTERN_READ) begin
                        state_r <= fcmd_pkg::FCMD_ST_DUMMY;
                     end else if (shift_nxt[7:0] == `FCMD_OP_NV_PATTERN_PROGRAM ||
                                  shift_nxt[7:0] == `FCMD_OP_VOL_PATTERN_WRITE) begin
                        state_r <= fcmd_pkg::FCMD_ST_DATA;
                     end
                  end
               end
               fcmd_pkg::FCMD_ST_DATA: begin
                  shift_r <= shift_nxt;
                  bits_r  <= bits_nxt;
               end
               fcmd_pkg::FCMD_ST_DUMMY: begin
                  state_r <= fcmd_pkg::FCMD_ST_READ; // see RL15
               end
               fcmd_pkg::FCMD_ST_READ: begin
                  state_r <= fcmd_pkg::FCMD_ST_READ;
               end
               fcmd_pkg::FCMD_ST_IDLE: begin
                  state_r <= fcmd_pkg::FCMD_ST_IDLE;
               end
            endcase
         end
      end
   end

   // Length checks at chip select rise
   assign len8  = (state_r == fcmd_pkg::FCMD_ST_INSTR) && (bits_r == `FCMD_INSTR_BITS);
   assign len16 = (state_r == fcmd_pkg::FCMD_ST_DATA) && (bits_r == `FCMD_INSTR_DATA_BITS);

   // Busy blocks all but the status clear
   assign exec_write_enable_cmd    = cs_rise & len8 & ~wip_r & (opcode_r == `FCMD_OP_WRITE_ENABLE); // see RL22
   assign exec_volatile_write_enable_cmd   = cs_rise & len8 & ~wip_r &
                         (opcode_r == `FCMD_OP_VOLATILE_WR_ENABLE); // see RL2
   assign exec_clear   = cs_rise & len8 & (opcode_r == `FCMD_OP_STATUS_CLEAR); // see RL5 RL6
   assign exec_enter   = cs_rise & len8 & ~wip_r & (opcode_r == `FCMD_OP_ENTER_WIDE_ADDR);
   assign exec_exit    = cs_rise & len8 & ~wip_r & (opcode_r == `FCMD_OP_EXIT_WIDE_ADDR);
   assign exec_nv_prog = cs_rise & len16 & ~wip_r & wel_r &
                         (opcode_r == `FCMD_OP_NV_PATTERN_PROGRAM); // see RL7 RL8
   assign exec_vol_wr  = cs_rise & len16 & ~wip_r & wel_r &
                         (opcode_r == `FCMD_OP_VOL_PATTERN_WRITE); // see RL12 RL13

   // Self-timed program of the stored pattern
   assign prog_done = prog_busy_r && (prog_cnt_r == 16'h0000);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         prog_busy_r  <= 1'b0;
         prog_cnt_r   <= 16'h0000;
         prog_start_r <= 1'b0;
         prog_data_r  <= 8'h00;
      end else if (i_ce) begin
         prog_start_r <= exec_nv_prog;
         if (exec_nv_prog) begin
            prog_busy_r <= 1'b1; // see RL9
            prog_cnt_r  <= 16'(`FCMD_NV_PROGRAM_CYCLES - 1);
            prog_data_r <= shift_r[7:0];
         end else if (prog_done) begin
            prog_busy_r <= 1'b0;
         end else if (prog_busy_r) begin
            prog_cnt_r <= prog_cnt_r - 16'h0001;
         end
      end
   end

   // Status register bits; a hardware set wins over a same-cycle clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wip_r  <= 1'(`FCMD_SR1_RESET >> `FCMD_SR1_WIP_POS);
         wel_r  <= 1'b0;
         perr_r <= 1'b0;
         eerr_r <= 1'b0;
      end else if (i_ce) begin
         if (exec_nv_prog) begin
            wip_r <= 1'b1; // see RL9
         end else if (prog_done) begin
            wip_r <= i_nv_program_fail | eerr_r; // see RL9 RL10
         end else if (perr_r | eerr_r | i_erase_error_set) begin
            wip_r <= ~exec_clear | i_erase_error_set;
         end else if (exec_clear) begin
            wip_r <= prog_busy_r; // see RL4
         end
         if (exec_write_enable_cmd) begin
            wel_r <= 1'b1; // see RL22
         end else if (exec_clear || prog_done || exec_vol_wr) begin
            wel_r <= 1'b0; // see RL4 RL9
         end
         if (prog_done && i_nv_program_fail) begin
            perr_r <= 1'b1; // see RL10
         end else if (exec_clear) begin
            perr_r <= 1'b0; // see RL4
         end
         if (i_erase_error_set) begin
            eerr_r <= 1'b1;
         end else if (exec_clear) begin
            eerr_r <= 1'b0; // see RL4
         end
      end
   end

   // Volatile-write arming; the latch itself is untouched
   always_ff @(posedge i_clock) begin
      if (i_rst || i_soft_reset) begin
         vol_armed_r <= 1'b0;
      end else if (i_ce) begin
         if (exec_volatile_write_enable_cmd) begin
            vol_armed_r <= 1'b1; // see RL1
         end else if (i_status_config_write_done || exec_write_enable_cmd) begin
            vol_armed_r <= 1'b0;
         end
      end
   end

   // Address length; four-byte-only commands live elsewhere and never read it
   always_ff @(posedge i_clock) begin
      if (i_rst || i_soft_reset) begin
         ads_r <= i_nv_address_length_bit; // see RL20
      end else if (i_ce) begin
         if (exec_enter) begin
            ads_r <= 1'b1; // see RL17 RL18
         end else if (exec_exit || i_write_any_register_clear_ads) begin
            ads_r <= 1'b0; // see RL19 RL21
         end
      end
   end

   // Volatile pattern copy
   always_ff @(posedge i_clock) begin
      if (i_rst || i_soft_reset) begin
         pattern_r <= i_nv_learning_pattern; // see RL23
      end else if (i_ce) begin
         if (exec_vol_wr) begin
            pattern_r <= shift_r[7:0]; // see RL13
         end
      end
   end

   // Read-out: bits change on falling clock, wrap for repeat reads
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_io      <= 4'h0;
         o_io_oe_n <= 4'hf;
         out_idx_r <= 3'h7;
      end else if (i_ce) begin
         if (pins.cs_n || state_r != fcmd_pkg::FCMD_ST_READ) begin
            o_io_oe_n <= 4'hf;
            out_idx_r <= 3'h7;
         end else if (sclk_fall) begin
            if (quad_r) begin
               o_io      <= out_idx_r[2] ? pattern_r[7:4] : pattern_r[3:0]; // see RL14
               o_io_oe_n <= 4'h0;
               out_idx_r <= {~out_idx_r[2], 2'b11}; // see RL16
            end else begin
               o_io      <= {2'b00, pattern_r[out_idx_r], 1'b0}; // see RL14
               o_io_oe_n <= 4'hd;
               out_idx_r <= out_idx_r - 3'h1; // see RL16
            end
         end
      end
   end

   assign o_volatile_status_register_1 = {6'h00, wel_r, wip_r};
   assign o_volatile_status_register_2 = {1'b0, eerr_r, perr_r, 5'h00};
   assign o_address_length_bit         = ads_r;
   assign o_volatile_write_armed       = vol_armed_r;
   assign o_learning_pattern           = pattern_r;
   assign o_nv_program_start           = prog_start_r;
   assign o_nv_program_data            = prog_data_r;

endmodule : fcmd_handler

// *** fcmd_handler_checker.sv ***
`timescale 1ns/1ps
`include "fcmd_regs.svh"
module fcmd_handler_checker (
   // Clocking and pins
   input wire logic       i_clock,
   input wire logic       i_rst,
   input wire logic       i_cs_n,
   // Side inputs
   input wire logic       i_soft_reset,
   input wire logic       i_write_any_register_clear_ads,
   input wire logic       i_nv_address_length_bit,
   input wire logic       i_nv_program_fail,
   // Watched outputs
   input wire logic [7:0] o_volatile_status_register_1,
   input wire logic [7:0] o_volatile_status_register_2,
   input wire logic       o_address_length_bit,
   input wire logic       o_volatile_write_armed,
   input wire logic [7:0] o_learning_pattern,
   input wire logic       o_nv_program_start
);
   logic       write_in_progress;
   logic       write_enable_latch;
   logic       perr;
   logic       eerr;
   logic [8:0] busy_cnt_r;

   assign write_in_progress  = o_volatile_status_register_1[`FCMD_SR1_WIP_POS];
   assign write_enable_latch  = o_volatile_status_register_1[`FCMD_SR1_WEL_POS];
   assign perr = o_volatile_status_register_2[`FCMD_SR2_PERR_POS];
   assign eerr = o_volatile_status_register_2[`FCMD_SR2_EERR_POS];

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // Length of the current busy stretch, saturating
   always_ff @(posedge i_clock) begin
      if (i_rst || !write_in_progress) busy_cnt_r <= 9'h000;
      else if (busy_cnt_r != 9'h1ff) busy_cnt_r <= busy_cnt_r + 9'h001;
   end

   property p_start_wel; o_nv_program_start |-> write_enable_latch; endproperty
   a_start_wel: assert property (p_start_wel)
      else $error("program start without write latch");
   property p_start_busy; o_nv_program_start |-> ##[0:2] write_in_progress; endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("program start without busy");
   property p_busy_len;
      $fell(write_in_progress) && !$past(perr || eerr) |-> !write_enable_latch && busy_cnt_r inside {[9'h0f6:9'h0fe]};
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("program busy length or latch wrong");
   property p_perr; $rose(perr) |-> $past(i_nv_program_fail) && write_in_progress; endproperty
   a_perr: assert property (p_perr)
      else $error("program error without failure");
   property p_busy_err; perr || eerr |-> write_in_progress; endproperty
   a_busy_err: assert property (p_busy_err)
      else $error("error flag set while not busy");
   property p_volatile_write_enable_cmd_wel; $rose(o_volatile_write_armed) |-> $stable(write_enable_latch); endproperty
   a_volatile_write_enable_cmd_wel: assert property (p_volatile_write_enable_cmd_wel)
      else $error("volatile enable touched write latch");
   property p_ads_frame;
      $changed(o_address_length_bit) |->
         i_cs_n || $past(i_soft_reset) || $past(i_write_any_register_clear_ads);
   endproperty
   a_ads_frame: assert property (p_ads_frame)
      else $error("address length changed inside a frame");
   property p_write_any_register_cmd; i_write_any_register_clear_ads |-> ##[1:2] !o_address_length_bit; endproperty
   a_write_any_register_cmd: assert property (p_write_any_register_cmd)
      else $error("address length not cleared by register path");
   property p_soft;
      i_soft_reset |-> ##[1:2] o_address_length_bit == i_nv_address_length_bit;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset did not reload address length");
   property p_pat; $changed(o_learning_pattern) |-> i_cs_n || $past(i_soft_reset); endproperty
   a_pat: assert property (p_pat)
      else $error("pattern changed inside a frame");

   c_start: cover property (o_nv_program_start);
   c_perr:  cover property ($rose(perr));
   c_ads:   cover property ($rose(o_address_length_bit));
endmodule : fcmd_handler_checker

// *** fcmd_host.sv ***
`timescale 1ns/1ps
module fcmd_host (
   // Clock and wire levels
   input  wire logic            i_clock,
   input  wire logic [3:0]      i_io,
   // Pins toward the device
   output fcmd_pkg::fcmd_pins_t o_pins
);
   initial o_pins = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

   // Four system clocks per phase keeps the link at 31.25 MHz
   task automatic half(input logic s);
      o_pins.sclk <= s;
      repeat (4) @(posedge i_clock);
   endtask : half

   task automatic frame(input logic [15:0] sh, input int nb, input logic quad,
                        input int rb, output logic [15:0] rd);
      rd = 16'h0000;
      o_pins.cs_n <= 1'b0;
      repeat (4) @(posedge i_clock);
      for (int i = 0; i < nb; i += quad ? 4 : 1) begin
         o_pins.io <= quad ? sh[15:12] : {~o_pins.io[3:1], sh[15]};
         sh = quad ? sh << 4 : sh << 1;
         half(1'b0);
         half(1'b1);
      end
      for (int j = 0; j <= rb && rb > 0; j++) begin
         // Released lines flip so a stale level never looks valid
         o_pins.io <= ~o_pins.io;
         half(1'b0);
         o_pins.sclk <= 1'b1;
         repeat (3) @(posedge i_clock);
         #1 if (j > 0) rd = quad ? {rd[11:0], i_io} : {rd[14:0], i_io[1]};
         @(posedge i_clock);
      end
      half(1'b0);
      o_pins.cs_n <= 1'b1;
      repeat (12) @(posedge i_clock);
   endtask : frame
endmodule : fcmd_host

// *** fcmd_pkg.sv ***
package fcmd_pkg;

   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] io;
   } fcmd_pins_t;

   typedef enum logic [2:0] {
      FCMD_ST_IDLE,
      FCMD_ST_INSTR,
      FCMD_ST_DATA,
      FCMD_ST_DUMMY,
      FCMD_ST_READ
   } fcmd_state_t;

endpackage : fcmd_pkg

// *** fcmd_regs.svh ***
`ifndef FCMD_REGS_SVH
`define FCMD_REGS_SVH

// Instruction codes
`define FCMD_OP_WRITE_ENABLE       8'h06
`define FCMD_OP_VOLATILE_WR_ENABLE 8'h50
`define FCMD_OP_STATUS_CLEAR       8'h30
`define FCMD_OP_NV_PATTERN_PROGRAM 8'h43
`define FCMD_OP_VOL_PATTERN_WRITE  8'h4a
`define FCMD_OP_PATTERN_READ       8'h41
`define FCMD_OP_ENTER_WIDE_ADDR    8'hb7
`define FCMD_OP_EXIT_WIDE_ADDR     8'he9

// Bit counts on the link
`define FCMD_INSTR_BITS            5'h08
`define FCMD_INSTR_DATA_BITS       5'h10
`define FCMD_BIT_COUNT_MAX         5'h1f

// Field positions
`define FCMD_SR1_WIP_POS           0
`define FCMD_SR1_WEL_POS           1
`define FCMD_SR2_PERR_POS          5
`define FCMD_SR2_EERR_POS          6
`define FCMD_CR2_ADS_POS           0
`define FCMD_CR2_NV_ADS_POS        1

// Reset values
`define FCMD_SR1_RESET             8'h00
`define FCMD_SR2_RESET             8'h00

// Self-timed non-volatile pattern program
`define FCMD_CLOCK_PERIOD_PS       4000
`define FCMD_NV_PROGRAM_TIME_NS    1000
`define FCMD_NV_PROGRAM_CYCLES \
   ((`FCMD_NV_PROGRAM_TIME_NS * 1000 + `FCMD_CLOCK_PERIOD_PS - 1) / `FCMD_CLOCK_PERIOD_PS)

`endif

// *** fcmd_sync.sv ***
`timescale 1ns/1ps
module fcmd_sync #(
   parameter int W = 6
) (
   // Clocking
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   // Asynchronous levels in, filtered levels out
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic lvl_r;
         // Level only moves once stages two and three agree
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               s1_r  <= 1'b1;
               s2_r  <= 1'b1;
               s3_r  <= 1'b1;
               lvl_r <= 1'b1;
            end else if (i_ce) begin
               s1_r <= i_async[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign o_level[g] = lvl_r;
      end
   endgenerate

endmodule : fcmd_sync

// *** test_fcmd_handler.sv ***
`timescale 1ns/1ps
module test_fcmd_handler;
   logic                 i_clock = 1'b0;
   logic                 i_rst = 1'b1;
   logic                 i_soft_reset = 1'b0;
   logic                 i_write_any_register_clear_ads = 1'b0;
   logic                 i_status_config_write_done = 1'b0;
   logic                 i_erase_error_set = 1'b0;
   logic                 i_nv_program_fail = 1'b0;
   logic                 quad = 1'b0;
   logic [3:0]           o_io;
   logic [3:0]           oe_n;
   logic [3:0]           io_w;
   logic [7:0]           sr1;
   logic [7:0]           sr2;
   logic [7:0]           pat;
   logic [7:0]           pdata;
   logic                 address_length_bit;
   logic                 armed;
   logic [15:0]          rd;
   fcmd_pkg::fcmd_pins_t pins;
   int                   failures = 0;
   int                   checks = 0;

   always #2 i_clock = ~i_clock;
   assign io_w = (oe_n & pins.io) | (~oe_n & o_io);

   fcmd_handler uut (
      .i_clock, .i_rst, .i_ce(1'b1), .i_cs_n(pins.cs_n), .i_sclk(pins.sclk), .i_io(io_w),
      .o_io, .o_io_oe_n(oe_n), .i_four_line_command_mode(quad),
      .i_nv_learning_pattern(8'h5a), .i_nv_address_length_bit(1'b0), .i_soft_reset,
      .i_write_any_register_clear_ads, .i_status_config_write_done, .i_erase_error_set,
      .i_nv_program_fail, .o_volatile_status_register_1(sr1),
      .o_volatile_status_register_2(sr2), .o_address_length_bit(address_length_bit),
      .o_volatile_write_armed(armed), .o_learning_pattern(pat),
      .o_nv_program_start(), .o_nv_program_data(pdata));
   fcmd_host host (.i_clock, .i_io(io_w), .o_pins(pins));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00,
                      input int nb = 8, input int rb = 0);
      host.frame({op, dat}, nb, quad, rb, rd);
   endtask : cmd

   task automatic finish_test;
      if (failures == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial begin
      repeat (30000) @(posedge i_clock);
      failures++;
      finish_test();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] p;
      p = 8'h5a;
      // Synchronisers load all ones in reset, the idle level of chip select only
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (6) @(posedge i_clock);
      chk(sr1 | sr2, 8'h00);
      chk({7'h00, address_length_bit}, 8'h00);
      chk(pat, 8'h5a);
      for (int q = 0; q < 2; q++) begin
         d = q ? 8'hc3 : 8'h3c;
         quad <= q[0];
         @(posedge i_clock);
         cmd(8'hb7);
         chk({7'h00, address_length_bit}, 8'h01);
         cmd(8'he9);
         chk({7'h00, address_length_bit}, 8'h00);
         cmd(8'h50, 8'h00, 16);
         chk({7'h00, armed}, 8'h00);
         cmd(8'h4a, d, 16);
         chk(pat, p);
         cmd(8'h06);
         chk(sr1, 8'h02);
         cmd(8'h50);
         chk({armed, sr1[6:0]}, 8'h82);
         i_status_config_write_done <= 1'b1;
         @(posedge i_clock);
         i_status_config_write_done <= 1'b0;
         repeat (3) @(posedge i_clock);
         chk({7'h00, armed}, 8'h00);
         cmd(8'h4a, d, 24);
         chk(pat, p);
         cmd(8'h4a, d, 16);
         chk({pat, sr1}, {d, 8'h00});
         cmd(8'h41, 8'h00, 8, q ? 4 : 16);
         chk(rd[15:8], d);
         chk(rd[7:0], d);
         p = d;
      end
      quad <= 1'b0;
      // Let the mode settle so host and device agree on line count
      @(posedge i_clock);
      cmd(8'h43, 8'h77, 16);
      chk(sr1, 8'h00);
      cmd(8'h06);
      cmd(8'h43, 8'h96, 16);
      chk(pdata, 8'h96);
      chk(sr1, 8'h03);
      repeat (250) @(posedge i_clock);
      chk(sr1, 8'h00);
      i_nv_program_fail <= 1'b1;
      cmd(8'h06);
      cmd(8'h43, 8'h24, 16);
      repeat (250) @(posedge i_clock);
      i_nv_program_fail <= 1'b0;
      chk({sr2[7:1], sr1[0]}, 8'h21);
      i_erase_error_set <= 1'b1;
      @(posedge i_clock);
      i_erase_error_set <= 1'b0;
      cmd(8'h30);
      chk(sr1 | sr2, 8'h00);
      cmd(8'h06);
      cmd(8'h30);
      chk(sr1, 8'h00);
      cmd(8'hb7);
      i_write_any_register_clear_ads <= 1'b1;
      @(posedge i_clock);
      i_write_any_register_clear_ads <= 1'b0;
      repeat (3) @(posedge i_clock);
      chk({7'h00, address_length_bit}, 8'h00);
      cmd(8'hb7);
      cmd(8'h06);
      cmd(8'h4a, 8'he1, 16);
      i_soft_reset <= 1'b1;
      @(posedge i_clock);
      i_soft_reset <= 1'b0;
      repeat (3) @(posedge i_clock);
      chk({6'h00, address_length_bit, armed}, 8'h00);
      chk(pat, 8'h5a);
      finish_test();
   end
endmodule : test_fcmd_handler

bind fcmd_handler fcmd_handler_checker u_chk (
   .i_clock, .i_rst, .i_cs_n, .i_soft_reset, .i_write_any_register_clear_ads,
   .i_nv_address_length_bit, .i_nv_program_fail, .o_volatile_status_register_1,
   .o_volatile_status_register_2, .o_address_length_bit, .o_volatile_write_armed,
   .o_learning_pattern, .o_nv_program_start);
